// [verilog/sbe_pkg.sv]
/*
 * sbe_pkg: register map, field layout, reset values and constants of the
 * scan binarize/enhance stage.
 * Assumes APB with 32-bit data and 12-bit byte addresses.
 */
package sbe_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_HNUM = 10'h008;
  localparam logic [9:0] IDX_HDEN = 10'h009;
  localparam logic [9:0] IDX_TRACK = 10'h00A;
  localparam logic [9:0] IDX_BIN = 10'h00B;
  localparam logic [9:0] IDX_EDGE = 10'h00C;
  localparam logic [9:0] IDX_CHAR = 10'h00D;
  localparam logic [9:0] IDX_STATUS = 10'h00E;
  // field positions
  localparam int F_WHITE = 4;
  localparam int F_PARAM = 8;
  localparam int F_VSTR = 4;
  localparam int F_HTHR = 8;
  localparam int F_VTHR = 16;
  localparam int F_CTHR = 8;
  localparam int F_FULL = 16;
  localparam int F_BG = 20;
  // binarize mode codes
  localparam logic [1:0] MODE_DITHER = 2'h2;
  localparam logic [1:0] MODE_DIFFUSE = 2'h3;
  // pixel, line and fifo sizes
  localparam int PIX_W = 5;
  localparam logic [4:0] PIX_MAX = 5'h1F;
  localparam int LINE_MAX = 2592;
  localparam int FIFO_DEPTH = 8;
  localparam logic [8:0] BG_RESET = 9'h100;
  // 4x4 ordered dither table, entry = {row, col}
  localparam logic [15:0][3:0] DITHER_TAB = {
    4'h5, 4'hD, 4'h7, 4'hF, 4'h9, 4'h1, 4'hB, 4'h3,
    4'h6, 4'hE, 4'h4, 4'hC, 4'hA, 4'h2, 4'h8, 4'h0};
  // processing parameters, shadowed and applied per line
  typedef struct packed {
    logic [7:0] hnum;
    logic [7:0] hden;
    logic [3:0] blk_speed;
    logic [3:0] wht_speed;
    logic [1:0] mode;
    logic [4:0] param;
    logic [3:0] hstr;
    logic [3:0] vstr;
    logic [4:0] hthr;
    logic [4:0] vthr;
    logic [2:0] cstr;
    logic [4:0] cthr;
  } sbe_cfg_t;
  // binary pixel toward the video output stage
  typedef struct packed {
    logic black;
    logic last;
  } sbe_bout_t;
endpackage

// [verilog/sbe_top.sv]
/*
 * sbe_top: horizontal reduction, background tracking, edge enhancement,
 * character enhancement in the dither and diffusion modes only, and binarization
 * of 5-bit pixels, with an APB register file and an output FIFO (sbe_fifo).
 * Assumes pixels arrive on pclk from the shading stage, one line ending with
 * pix_last; the video output stage drains bin_* with bin_ready.
 */
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module sbe_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH:0] vld;
  logic push;
  logic pop;

  assign vld[DEPTH] = 1'b0;
  assign push = in_valid & ~vld[DEPTH-1];
  assign pop = vld[0] & out_ready;

  // shift-register entries, head at slot 0
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic prev_v;
    assign prev_v = (i == 0) ? 1'b1 : vld[(i == 0) ? 0 : i-1];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        vld[i] <= 1'b0;
        mem[i] <= '0;
      end else if (pop) begin
        vld[i] <= vld[i+1] | (push & vld[i]);
        if (vld[i+1]) begin
          mem[i] <= mem[(i == DEPTH-1) ? i : i+1];
        end else if (push & vld[i]) begin
          mem[i] <= in_data;
        end
      end else if (push & ~vld[i] & prev_v) begin
        vld[i] <= 1'b1;
        mem[i] <= in_data;
      end
    end
  end

  assign out_valid = vld[0];
  assign out_data = mem[0];
  // not-full kept in a flop so ready leaves a register; a pop frees one slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) in_ready <= 1'b1;
    else in_ready <= pop | ~(vld[DEPTH-1] | (push & vld[DEPTH-2]));
  end
  sequence s_stalled;
    out_valid && !out_ready;
  endsequence
  AST_FIFO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    s_stalled |=> out_valid && $stable(out_data))
    else $error("fifo head changed while stalled");
endmodule

////////////////////////////////////////////////////////////////////////////
module sbe_top
  import sbe_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pix_valid,
  input wire logic [4:0] pix_data,
  input wire logic pix_last,
  output logic pix_ready,
  output logic bin_valid,
  output logic bin_black,
  output logic bin_last,
  input wire logic bin_ready
);
  sbe_cfg_t shd;
  sbe_cfg_t act;
  sbe_bout_t fifo_in;
  sbe_bout_t fifo_out;
  logic sol;
  logic accept;
  logic push;
  logic keep;
  logic [8:0] acc;
  logic [8:0] next_acc;
  logic [8:0] bg_acc;
  logic [11:0] col;
  logic [1:0] row;
  logic [4:0] prev_pix;
  logic [4:0] above_pix;
  logic [4:0] line_mem [LINE_MAX];
  logic [4:0] norm;
  logic signed [6:0] dh;
  logic signed [6:0] dv;
  logic signed [11:0] h_add;
  logic signed [11:0] v_add;
  logic signed [11:0] c_add;
  logic signed [12:0] sum;
  logic [4:0] val;
  logic [4:0] dth;
  logic signed [7:0] dif_v;
  logic signed [6:0] err;
  logic bin_bit;
  logic [9:0] idx;
  logic hit;
  logic wr;

  assign accept = pix_valid & pix_ready;

  //////////////////////////////////////////////////////////////////////////
  // apb slave
  assign idx = paddr[11:2];
  assign hit = (paddr[1:0] == 2'h0) &&
    (idx inside {IDX_HNUM, IDX_HDEN, IDX_TRACK, IDX_BIN, IDX_EDGE, IDX_CHAR,
                 IDX_STATUS});
  assign wr = psel & penable & pready & pwrite;

  // zero-wait answer: ready raised during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~hit;
    end
  end

  // read data, captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= 32'h0;
      unique case (idx)
        IDX_HNUM: prdata[7:0] <= shd.hnum;
        IDX_HDEN: prdata[7:0] <= shd.hden;
        IDX_TRACK: prdata[7:0] <= {shd.wht_speed, shd.blk_speed};
        IDX_BIN: prdata[12:0] <= {shd.param, 6'h00, shd.mode};
        IDX_EDGE: prdata[20:0] <= {shd.vthr, 3'h0, shd.hthr, shd.vstr, shd.hstr};
        IDX_CHAR: prdata[12:0] <= {shd.cthr, 5'h00, shd.cstr};
        IDX_STATUS: prdata[24:0] <= {bg_acc[8:4], 3'h0, ~pix_ready, 4'h0, col};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // shadow registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shd <= '0;
    end else if (wr & hit) begin
      unique case (idx)
        IDX_HNUM: shd.hnum <= pwdata[7:0];
        IDX_HDEN: shd.hden <= pwdata[7:0];
        IDX_TRACK: {shd.wht_speed, shd.blk_speed} <= pwdata[7:0];
        IDX_BIN: {shd.param, shd.mode} <= {pwdata[F_PARAM+:5], pwdata[1:0]};
        IDX_EDGE: begin
          {shd.vstr, shd.hstr} <= pwdata[7:0];
          shd.hthr <= pwdata[F_HTHR+:5];
          shd.vthr <= pwdata[F_VTHR+:5];
        end
        IDX_CHAR: {shd.cthr, shd.cstr} <= {pwdata[F_CTHR+:5], pwdata[2:0]};
        default: shd <= shd;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line framing: settings copied only between lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= '0;
      sol <= 1'b1;
    end else begin
      if (sol & ~accept) begin
        act <= shd;
      end
      if (accept) begin
        sol <= pix_last;
      end
    end
  end
  AST_LINE_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    !sol |=> $stable(act))
    else $error("settings changed inside a line");

  // column, row and neighbour pixels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col <= 12'h000;
      row <= 2'h0;
      prev_pix <= 5'h00;
    end else if (accept) begin
      col <= pix_last ? 12'h000 : (col == 12'(LINE_MAX-1) ? col : col + 12'h001);
      row <= pix_last ? row + 2'h1 : row;
      prev_pix <= pix_data;
    end
  end

  // previous line store
  always_ff @(posedge pclk) begin
    if (accept) begin
      line_mem[col] <= pix_data;
    end
  end
  assign above_pix = line_mem[col];

  //////////////////////////////////////////////////////////////////////////
  // horizontal reduction accumulator
  always_comb begin
    next_acc = (sol ? 9'h000 : acc) + {1'b0, act.hnum} + 9'h001;
    keep = next_acc >= {1'b0, act.hden} + 9'h001;
    if (keep) begin
      next_acc = (next_acc > {1'b0, act.hden} + 9'h001) ?
        next_acc - {1'b0, act.hden} - 9'h001 : 9'h000;
    end
    if (next_acc > {1'b0, act.hden}) begin
      next_acc = 9'h000;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 9'h000;
    end else if (accept) begin
      acc <= next_acc;
    end
  end
  AST_RATIO_UNITY: assert property (@(posedge pclk) disable iff (!presetn)
    accept && act.hnum >= act.hden |-> push)
    else $error("pixel dropped at unity ratio");

  // background level tracker, 5.4 fixed point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_acc <= BG_RESET;
    end else if (accept) begin
      if (pix_data < bg_acc[8:4]) begin
        bg_acc <= (bg_acc > {5'h00, act.blk_speed}) ?
          bg_acc - {5'h00, act.blk_speed} : 9'h000;
      end else if (pix_data > bg_acc[8:4]) begin
        bg_acc <= (bg_acc < 9'h1FF - {5'h00, act.wht_speed}) ?
          bg_acc + {5'h00, act.wht_speed} : 9'h1FF;
      end
    end
  end
  AST_BLACK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    accept && act.blk_speed == 4'h0 |=> bg_acc >= $past(bg_acc))
    else $error("dark tracking moved at speed zero");
  AST_WHITE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    accept && act.wht_speed == 4'h0 |=> bg_acc <= $past(bg_acc))
    else $error("light tracking moved at speed zero");

  //////////////////////////////////////////////////////////////////////////
  // background correction and enhancement
  always_comb begin
    sum = 13'(pix_data) + 13'(PIX_MAX) - 13'(bg_acc[8:4]);
    norm = (sum > 13'(PIX_MAX)) ? PIX_MAX : sum[4:0];
    dh = sol ? 7'sd0 : 7'($signed({2'b00, pix_data}) - $signed({2'b00, prev_pix}));
    dv = (row == 2'h0 && col == 12'h000) ? 7'sd0 :
      7'($signed({2'b00, pix_data}) - $signed({2'b00, above_pix}));
    h_add = 12'sd0;
    v_add = 12'sd0;
    c_add = 12'sd0;
    if (act.hstr != 4'h0 && (dh[6] ? -dh : dh) > 7'(act.hthr)) begin
      h_add = 12'((12'(dh) * $signed({8'h00, act.hstr})) >>> 3);
    end
    if (act.vstr != 4'h0 && (dv[6] ? -dv : dv) > 7'(act.vthr)) begin
      v_add = 12'((12'(dv) * $signed({8'h00, act.vstr})) >>> 3);
    end
    if (act.mode[1] && act.cstr != 3'h0 &&
        (dh < 0 ? -dh : dh) + (dv < 0 ? -dv : dv) > 7'(act.cthr)) begin
      c_add = 12'(((12'(dh) + 12'(dv)) * $signed({9'h000, act.cstr})) >>> 3);
    end
    sum = 13'(norm) + 13'(h_add) + 13'(v_add) + 13'(c_add);
    val = sum[12] ? 5'h00 : (sum > 13'(PIX_MAX) ? PIX_MAX : sum[4:0]);
  end
  AST_HSHARP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    act.hstr == 4'h0 |-> h_add == 12'sd0)
    else $error("horizontal sharpening while off");
  AST_CHAR_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    act.cstr == 3'h0 || !act.mode[1] |-> c_add == 12'sd0)
    else $error("character sharpening while off");

  //////////////////////////////////////////////////////////////////////////
  // binarization
  always_comb begin
    dth = {DITHER_TAB[{row, col[1:0]}], 1'b1};
    dif_v = 8'(val) + 8'(err);
    unique case (act.mode)
      MODE_DITHER: bin_bit = val < dth;
      MODE_DIFFUSE: bin_bit = dif_v < $signed({3'h0, act.param});
      default: bin_bit = val < act.param;
    endcase
  end

  // diffusion error carried to the next pixel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 7'sd0;
    end else if (accept) begin
      if (pix_last || act.mode != MODE_DIFFUSE) begin
        err <= 7'sd0;
      end else begin
        err <= 7'(bin_bit ? dif_v : dif_v - 8'sd31);
      end
    end
  end
  AST_SLICE: assert property (@(posedge pclk) disable iff (!presetn)
    push && !act.mode[1] |-> fifo_in.black == (val < act.param))
    else $error("slice output wrong");
  AST_DITHER: assert property (@(posedge pclk) disable iff (!presetn)
    push && act.mode == MODE_DITHER |-> fifo_in.black == (val < dth))
    else $error("dither output wrong");

  //////////////////////////////////////////////////////////////////////////
  // output buffer, its ready stalls the pixel input
  assign push = accept & (keep | pix_last);
  assign fifo_in = '{black: bin_bit, last: pix_last};
  sbe_fifo #(
    .WIDTH($bits(sbe_bout_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(push),
    .in_data(fifo_in),
    .in_ready(pix_ready),
    .out_valid(bin_valid),
    .out_data(fifo_out),
    .out_ready(bin_ready)
  );
  assign bin_black = fifo_out.black;
  assign bin_last = fifo_out.last;
endmodule

// [tb/sbe_sink.sv]
/*
 * sbe_sink: model of the video output stage; pops binary pixels into a queue.
 * Assumes bin_* of sbe_top on pclk; the bench drives stall after a rising edge.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module sbe_sink
  import sbe_pkg::*;
(
  input wire logic pclk,
  input wire logic stall,
  input wire logic bin_valid,
  input wire logic bin_black,
  input wire logic bin_last,
  output logic bin_ready
);
  sbe_bout_t got[$];
  // ready unless the bench holds the stage back
  assign bin_ready = !stall;
  // capture each popped pixel in order
  always @(posedge pclk) begin
    if (bin_valid && bin_ready) begin
      got.push_back('{black: bin_black, last: bin_last});
    end
  end
endmodule

// [tb/test_scan_binarize_enhance_cfg.sv]
/*
 * test_scan_binarize_enhance_cfg: self-checking bench of sbe_top.
 * Assumes sbe_pkg register map and the zero-wait APB slave of sbe_top.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module test_scan_binarize_enhance_cfg
  import sbe_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pix_valid, pix_last, pix_ready, bin_valid, bin_black, bin_last, bin_ready;
  logic [4:0] pix_data, lvl;
  logic [7:0] a;
  logic [3:0][7:0] dres;
  int n_fail = 0;
  int cmp_count = 0;
  // register rows: index and readback after writing all ones
  logic [9:0] ridx [6] = '{IDX_HNUM, IDX_HDEN, IDX_TRACK, IDX_BIN, IDX_EDGE, IDX_CHAR};
  logic [31:0] rexp [6] = '{32'hFF, 32'hFF, 32'hFF, 32'h1F03, 32'h1F1FFF, 32'h1F07};

  sbe_top sbe_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_last(pix_last), .pix_ready(pix_ready), .bin_valid(bin_valid),
    .bin_black(bin_black), .bin_last(bin_last), .bin_ready(bin_ready));
  sbe_sink sbe_sink_i (.pclk(pclk), .stall(stall), .bin_valid(bin_valid),
    .bin_black(bin_black), .bin_last(bin_last), .bin_ready(bin_ready));

  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high at a rising edge
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rdv = prdata;
    errv = pslverr;
    if (pready !== 1'b1) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task rd(input logic [9:0] i);
    apb(1'b0, {i, 2'b00}, 32'h0);
  endtask

  // one pixel, held until taken
  task send(input logic [4:0] p, input logic l);
    int n;
    n = 0;
    @(posedge pclk);
    pix_valid <= 1'b1;
    pix_data <= p;
    pix_last <= l;
    @(posedge pclk);
    while (pix_ready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (pix_ready !== 1'b1) chk(32'h0, 32'h1);
    pix_valid <= 1'b0;
  endtask

  task line(input int n, input logic [39:0] pv);
    for (int i = 0; i < n; i++) send(pv[5*i+:5], i == n - 1);
  endtask

  // wait for n binary pixels, check the line end, return black bits
  task take(input int n, output logic [7:0] blk);
    int w;
    sbe_bout_t e;
    w = 0;
    blk = 8'h00;
    while (sbe_sink_i.got.size() < n && w < 300) begin
      @(negedge pclk);
      w++;
    end
    chk(sbe_sink_i.got.size(), n);
    for (int i = 0; i < n && sbe_sink_i.got.size() > 0; i++) begin
      e = sbe_sink_i.got.pop_front();
      blk[i] = e.black;
      chk(e.last, i == n - 1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    #(50 * 20000);
    n_fail++;
    print_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, stall} = '0;
    {pix_valid, pix_data, pix_last} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({pready, pslverr, pix_ready, bin_valid}, 4'b0010);
    // register rows: reset value, writable bits, clear again
    for (int i = 0; i < 6; i++) begin
      rd(ridx[i]);
      chk(rdv, 32'h0);
      chk(errv, 1'b0);
      wr(ridx[i], 32'hFFFFFFFF);
      rd(ridx[i]);
      chk(rdv, rexp[i]);
      wr(ridx[i], 32'h0);
    end
    // unmapped and misaligned accesses
    rd(10'h010);
    chk(errv, 1'b1);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h021, 32'h1);
    chk(errv, 1'b1);
    // slice 20 in both simple codes, edges off or above any change
    for (int m = 0; m < 2; m++) begin
      for (int e = 0; e < 2; e++) begin
        wr(IDX_BIN, 32'h1400 | m);
        wr(IDX_EDGE, e ? 32'h1F1FFF : 32'h0);
        line(4, {20'h0, 5'd30, 5'd5, 5'd4, 5'd3});
        take(4, a);
        chk(a, 8'h03);
        line(4, {20'h0, 5'd3, 5'd4, 5'd5, 5'd30});
        take(4, a);
        chk(a, 8'h0C);
      end
    end
    wr(IDX_EDGE, 32'h0);
    // reduction by one half keeps every second pixel
    wr(IDX_HDEN, 32'h1);
    line(4, {20'h0, 5'd3, 5'd31, 5'd3, 5'd31});
    take(2, a);
    chk(a, 8'h03);
    wr(IDX_HDEN, 32'h0);
    // slice change in mid-line waits for the next line
    send(5'd3, 1'b0);
    wr(IDX_BIN, 32'h0);
    send(5'd3, 1'b1);
    take(2, a);
    chk(a, 8'h03);
    line(2, {30'h0, 5'd3, 5'd3});
    take(2, a);
    chk(a, 8'h00);
    // diffusion: parameter is the black level
    wr(IDX_BIN, 32'h1003);
    line(1, 40'h0);
    take(1, a);
    chk(a, 8'h01);
    wr(IDX_BIN, 32'h0F03);
    line(1, 40'h0);
    take(1, a);
    chk(a, 8'h00);
    // dither: same four lines with parameter 0 and 31
    for (int k = 0; k < 2; k++) begin
      wr(IDX_BIN, k ? 32'h1F02 : 32'h0002);
      for (int l = 0; l < 4; l++) begin
        line(4, {20'h0, {4{5'd8}}});
        take(4, a);
        if (k == 0) dres[l] = a;
        else chk(a, dres[l]);
      end
    end
    // fifo fills while the sink stalls, then drains
    wr(IDX_BIN, 32'h1400);
    stall <= 1'b1;
    line(8, {8{5'd3}});
    @(negedge pclk);
    chk(pix_ready, 1'b0);
    rd(IDX_STATUS);
    chk(rdv[F_FULL], 1'b1);
    stall <= 1'b0;
    take(8, a);
    chk(a, 8'hFF);
    chk(bin_valid, 1'b0);
    // background tracking speeds
    wr(IDX_TRACK, 32'h0);
    line(4, 40'h0);
    take(4, a);
    rd(IDX_STATUS);
    chk(rdv[F_BG+:5], 5'h10);
    wr(IDX_TRACK, 32'h0F);
    line(4, 40'h0);
    take(4, a);
    rd(IDX_STATUS);
    lvl = rdv[F_BG+:5];
    chk(lvl < 5'h10, 1'b1);
    wr(IDX_TRACK, 32'hF0);
    line(8, {8{5'd31}});
    take(8, a);
    rd(IDX_STATUS);
    chk(rdv[F_BG+:5] > lvl, 1'b1);
    print_verdict;
  end
endmodule
